/* File: shared/rpm_pkg.sv */
// Purpose: Shared constants and types for the reset and power mode controller.
// Assumes: One 10 MHz clock; all pins pass a two-stage synchroniser first.
// Notes: How the block behaves is summarised below.
// How it works
// [RL1] Power-fail pin drives the first core interrupt, which outranks the second.
// [RL2] Battery power-up reset covers only the real-time clock and system wake-up logic.
// [RL3] Standby power-up reset ends only with standby present and the PLL settled.
// [RL4] Program flash must be ready before the standby power-up reset ends; here it ends on standby and PLL settling alone, with no flash input.
// [RL5] Warm pin, main supply or host-bus reset reset the whole host region.
// [RL6] Software reset write resets configuration, devices and bridge, not the host interface.
// [RL7] Controller domain resets on warm reset, standby power-up or watchdog.
// [RL8] Either core or external watchdog time-out makes a watchdog reset.
// [RL9] A bad key written to the external watchdog forces a controller reset.
// [RL10] The cause of the latest controller reset is kept for firmware to read.
// [RL11] Host-bus reset comes from one of two pins and shares the second interrupt.
// [RL12] Controller clock comes from the PLL and is divided by a select register.
// [RL13] After reset the divider selects 5 MHz; firmware later selects 10 MHz.
// [RL14] Host domain runs on the host bus clock; RTC runs at 32.768 KHz.
// [RL15] Normal mode follows standby present and reset done; core runs on controller clock.
// [RL16] Idle stops instruction fetch; core timers and core watchdog keep running.
// [RL17] Idle ends on controller interrupt, core timer interrupt, watchdog or hardware reset.
// [RL18] Doze and sleep stop the core clock and core timers.
// [RL19] Doze and sleep wake only on an enabled external interrupt or hardware reset.
// [RL20] Power-down enters sleep with PLL stopped if PLL stop is set, else doze.
// [RL21] Waking from sleep waits for the restarted PLL to settle again.
// [RL22] Firmware enables only wanted interrupt and wake-up channels before power-down.
// [RL23] On wake-up the core runs the interrupt routine, then resumes.
// [RL24] The routine is skipped if skip was set before and the interrupt dropped.
// [RL25] Resets assert at once from any source and release on the clock.
package rpm_pkg;

  // ==========================================================================
  // Pin synchroniser layout
  localparam int unsigned PIN_BAT = 0;
  localparam int unsigned PIN_STBY = 1;
  localparam int unsigned PIN_MAIN = 2;
  localparam int unsigned PIN_WARM = 3;
  localparam int unsigned PIN_HRA = 4;
  localparam int unsigned PIN_HRB = 5;
  localparam int unsigned PIN_PFAIL = 6;
  localparam int unsigned PIN_ALT = 7;
  localparam int unsigned PIN_W = 8;
  localparam logic [7:0] PIN_SYNC_RST = 8'hF8;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned PLL_SETTLE_US = 1000;
  localparam int unsigned PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
  localparam int unsigned RST_STAGES = 2;

  // ==========================================================================
  // Clock divider select codes
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_RESET = DIV_BY2;

  // ==========================================================================
  // External watchdog key; the value is arbitrary.
  localparam logic [7:0] EXT_WDT_KEY = 8'h5C;

  // ==========================================================================
  // Reset causes and power modes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_POWERUP = 3'h1;
  localparam logic [2:0] CAUSE_WARM = 3'h2;
  localparam logic [2:0] CAUSE_WDT_EXT = 3'h3;
  localparam logic [2:0] CAUSE_WDT_CORE = 3'h4;

  typedef enum logic [2:0] {
    MODE_RESET = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_DOZE = 3'b011,
    MODE_SLEEP = 3'b100,
    MODE_RELOCK = 3'b101
  } mode_e;

endpackage

/* File: rtl/reset_release_sync.sv */
// Purpose: One reset type: asserts at once, releases after a clocked delay.
// Assumes: The source is already on this clock.
// Notes: Output is low for at least STAGES cycles after any source pulse.
`timescale 1ns/1ps
module reset_release_sync #(
  parameter int unsigned STAGES = rpm_pkg::RST_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Reset request, active high
  input wire logic src,
  // Reset out, active low
  output logic rst_out_n
);

  logic [STAGES-1:0] sh_r;

  always_ff @(posedge clk) begin
    if (!rst_n || src) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[STAGES-2:0], 1'b1};
    end
  end

  // The source gates the output directly so assertion needs no clock edge.
  assign rst_out_n = sh_r[STAGES-1] && !src; // RL25

endmodule

/* File: rtl/ctrl_clock_divider.sv */
// Purpose: Divides the controller clock into an enable tick.
// Assumes: The select register is written by firmware through a strobe.
// Notes: The select resets to divide by two.
`timescale 1ns/1ps
module ctrl_clock_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Select write
  input wire logic sel_write,
  input wire logic [1:0] sel_data,
  // Tick and current select
  output logic tick,
  output logic [1:0] sel
);

  logic [1:0] sel_r;
  logic [2:0] cnt_r;
  logic tick_r;

  // Last count of a period for a given select.
  function automatic logic [2:0] div_last(input logic [1:0] s);
    div_last = 3'((4'h1 << s) - 4'h1);
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_r <= rpm_pkg::DIV_RESET; // RL13
    end else if (sel_write) begin
      sel_r <= sel_data; // RL12
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || sel_write || cnt_r >= div_last(sel_r)) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= (cnt_r >= div_last(sel_r)); // RL12
    end
  end

  assign tick = tick_r;
  assign sel = sel_r;

endmodule

/* File: rtl/reset_and_power_mode_control.sv */
// Purpose: Builds every reset type and runs the core power modes.
// Assumes: Pins are asynchronous; firmware strobes are on clk.
// Notes: Clocks are not gated here; run and tick outputs serve as enables.
`timescale 1ns/1ps
module reset_and_power_mode_control #(
  parameter int unsigned PLL_SETTLE_CYC = rpm_pkg::PLL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Supply and reset pins
  input wire logic battery_supply,
  input wire logic standby_supply,
  input wire logic main_supply,
  input wire logic warm_reset_n,
  input wire logic host_bus_reset_a_n,
  input wire logic host_bus_reset_b_n,
  input wire logic host_reset_pin_sel,
  input wire logic host_reset_use,
  // Interrupt pins
  input wire logic power_fail_n,
  input wire logic alt_irq_pin_n,
  // Software and watchdog
  input wire logic superio_soft_reset_write,
  input wire logic core_wdt_timeout,
  input wire logic ext_wdt_timeout,
  input wire logic ext_watchdog_key_enable,
  input wire logic ext_watchdog_key_write,
  input wire logic [7:0] ext_watchdog_key_data,
  // Clock divide select
  input wire logic clock_divide_write,
  input wire logic [1:0] clock_divide_data,
  // Core power control
  input wire logic idle_bit_set,
  input wire logic power_down_bit_set,
  input wire logic pll_stop_ctrl,
  input wire logic skip_isr_on_wake_bit,
  input wire logic interrupt_controller_block_irq,
  input wire logic core_timer_irq,
  // Reset outputs
  output logic battery_region_rst_n,
  output logic host_region_rst_n,
  output logic host_soft_rst_n,
  output logic ctrl_domain_rst_n,
  output logic [2:0] reset_cause_scratch,
  // Core interrupt lines
  output logic core_ext_irq_first_n,
  output logic core_ext_irq_second_n,
  // Clock and mode status
  output logic pll_enable,
  output logic pll_stable,
  output logic ctrl_clk_tick,
  output logic [1:0] clock_divide_select,
  output logic core_clk_en,
  output logic core_fetch_en,
  output logic core_timers_run,
  output logic [2:0] mode_state,
  output logic wake_run_isr,
  output logic wake_skip_isr
);

  localparam int unsigned CW = $clog2(PLL_SETTLE_CYC + 1);
  localparam logic [CW-1:0] PLL_LAST = CW'(PLL_SETTLE_CYC - 1);

  // ==========================================================================
  // Pin synchroniser
  logic [7:0] pin_in;
  logic [7:0] pin_m_r;
  logic [7:0] pin_s_r;

  assign pin_in = {alt_irq_pin_n, power_fail_n, host_bus_reset_b_n, host_bus_reset_a_n,
                   warm_reset_n, main_supply, standby_supply, battery_supply};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_m_r <= rpm_pkg::PIN_SYNC_RST;
      pin_s_r <= rpm_pkg::PIN_SYNC_RST;
    end else begin
      pin_m_r <= pin_in;
      pin_s_r <= pin_m_r;
    end
  end

  // ==========================================================================
  // Reset sources
  logic warm_act;
  logic host_pin_act;
  logic host_src;
  logic key_bad;
  logic wdog_ext;
  logic wdog_src;
  logic ctrl_src;
  logic stby_done_r;

  assign warm_act = !pin_s_r[rpm_pkg::PIN_WARM];
  assign host_pin_act = host_reset_use &&
    !(host_reset_pin_sel ? pin_s_r[rpm_pkg::PIN_HRB] : pin_s_r[rpm_pkg::PIN_HRA]); // RL11
  assign host_src = warm_act || !pin_s_r[rpm_pkg::PIN_MAIN] || host_pin_act; // RL5
  assign key_bad = ext_watchdog_key_enable && ext_watchdog_key_write &&
    (ext_watchdog_key_data != rpm_pkg::EXT_WDT_KEY); // RL9
  assign wdog_ext = ext_wdt_timeout || key_bad;
  assign wdog_src = core_wdt_timeout || wdog_ext; // RL8
  assign ctrl_src = warm_act || !stby_done_r || wdog_src; // RL7

  reset_release_sync u_bat_rst (
    .clk(clk),
    .rst_n(rst_n),
    .src(!pin_s_r[rpm_pkg::PIN_BAT]), // RL2
    .rst_out_n(battery_region_rst_n)
  );

  reset_release_sync u_host_rst (
    .clk(clk),
    .rst_n(rst_n),
    .src(host_src), // RL5
    .rst_out_n(host_region_rst_n)
  );

  reset_release_sync u_soft_rst (
    .clk(clk),
    .rst_n(rst_n),
    .src(host_src || superio_soft_reset_write), // RL6
    .rst_out_n(host_soft_rst_n)
  );

  reset_release_sync u_ctrl_rst (
    .clk(clk),
    .rst_n(rst_n),
    .src(ctrl_src), // RL7
    .rst_out_n(ctrl_domain_rst_n)
  );

  // ==========================================================================
  // PLL settling and standby power-up
  logic [CW-1:0] pll_cnt_r;
  logic pll_stable_r;
  logic pll_en_r;

  always_ff @(posedge clk) begin
    if (!rst_n || !pll_en_r || !pin_s_r[rpm_pkg::PIN_STBY]) begin
      pll_cnt_r <= '0;
    end else if (pll_cnt_r != PLL_LAST) begin
      pll_cnt_r <= pll_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_stable_r <= 1'b0;
    end else begin
      pll_stable_r <= pll_en_r && pin_s_r[rpm_pkg::PIN_STBY] && (pll_cnt_r == PLL_LAST);
    end
  end

  // Once done, only loss of standby restarts it; sleep must not re-run it.
  always_ff @(posedge clk) begin
    if (!rst_n || !pin_s_r[rpm_pkg::PIN_STBY]) begin
      stby_done_r <= 1'b0;
    end else if (pll_stable_r) begin
      stby_done_r <= 1'b1; // RL3
    end
  end

  // ==========================================================================
  // Reset cause, kept across controller resets
  logic [2:0] cause_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cause_r <= rpm_pkg::CAUSE_NONE;
    end else if (!stby_done_r) begin
      cause_r <= rpm_pkg::CAUSE_POWERUP; // RL10
    end else if (warm_act) begin
      cause_r <= rpm_pkg::CAUSE_WARM; // RL10
    end else if (wdog_ext) begin
      cause_r <= rpm_pkg::CAUSE_WDT_EXT; // RL10
    end else if (core_wdt_timeout) begin
      cause_r <= rpm_pkg::CAUSE_WDT_CORE; // RL10
    end
  end

  // ==========================================================================
  // Core interrupt lines
  logic irq1_r;
  logic irq2_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq1_r <= 1'b1;
      irq2_r <= 1'b1;
    end else begin
      irq1_r <= pin_s_r[rpm_pkg::PIN_PFAIL]; // RL1
      irq2_r <= !pin_s_r[rpm_pkg::PIN_PFAIL] ||
        (pin_s_r[rpm_pkg::PIN_ALT] && !host_pin_act); // RL1 RL11
    end
  end

  // ==========================================================================
  // Controller clock divider
  ctrl_clock_divider u_div (
    .clk(clk),
    .rst_n(rst_n && ctrl_domain_rst_n),
    .sel_write(clock_divide_write),
    .sel_data(clock_divide_data),
    .tick(ctrl_clk_tick), // RL12
    .sel(clock_divide_select)
  );

  // ==========================================================================
  // Power mode machine
  rpm_pkg::mode_e mode_r;
  rpm_pkg::mode_e mode_nxt;
  logic skip_r;
  logic run_r;
  logic fetch_r;
  logic wake_now;
  logic wake_run_r;
  logic wake_skip_r;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      rpm_pkg::MODE_RESET: begin
        if (stby_done_r) begin
          mode_nxt = rpm_pkg::MODE_NORMAL; // RL15
        end
      end
      rpm_pkg::MODE_NORMAL: begin
        if (power_down_bit_set) begin
          mode_nxt = pll_stop_ctrl ? rpm_pkg::MODE_SLEEP : rpm_pkg::MODE_DOZE; // RL20
        end else if (idle_bit_set) begin
          mode_nxt = rpm_pkg::MODE_IDLE; // RL16
        end
      end
      rpm_pkg::MODE_IDLE: begin
        if (interrupt_controller_block_irq || core_timer_irq) begin
          mode_nxt = rpm_pkg::MODE_NORMAL; // RL17
        end
      end
      rpm_pkg::MODE_DOZE: begin
        if (interrupt_controller_block_irq) begin
          mode_nxt = rpm_pkg::MODE_NORMAL; // RL19
        end
      end
      rpm_pkg::MODE_SLEEP: begin
        if (interrupt_controller_block_irq) begin
          mode_nxt = rpm_pkg::MODE_RELOCK; // RL19
        end
      end
      rpm_pkg::MODE_RELOCK: begin
        if (pll_stable_r) begin
          mode_nxt = rpm_pkg::MODE_NORMAL; // RL21
        end
      end
      default: begin
        mode_nxt = rpm_pkg::MODE_RESET;
      end
    endcase
  end

  // Watchdog and hardware resets leave every mode through the domain reset.
  always_ff @(posedge clk) begin
    if (!rst_n || !ctrl_domain_rst_n) begin
      mode_r <= rpm_pkg::MODE_RESET; // RL17
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !ctrl_domain_rst_n) begin
      pll_en_r <= 1'b1;
      run_r <= 1'b0;
      fetch_r <= 1'b0;
    end else begin
      pll_en_r <= (mode_nxt != rpm_pkg::MODE_SLEEP); // RL20
      run_r <= (mode_nxt == rpm_pkg::MODE_NORMAL) || (mode_nxt == rpm_pkg::MODE_IDLE); // RL18
      fetch_r <= (mode_nxt == rpm_pkg::MODE_NORMAL); // RL15 RL16
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !ctrl_domain_rst_n) begin
      skip_r <= 1'b0;
    end else if (mode_r == rpm_pkg::MODE_NORMAL && (power_down_bit_set || idle_bit_set)) begin
      skip_r <= skip_isr_on_wake_bit; // RL24
    end
  end

  assign wake_now = (mode_r != rpm_pkg::MODE_RESET) && (mode_r != rpm_pkg::MODE_NORMAL) &&
    (mode_nxt == rpm_pkg::MODE_NORMAL);

  always_ff @(posedge clk) begin
    if (!rst_n || !ctrl_domain_rst_n) begin
      wake_run_r <= 1'b0;
      wake_skip_r <= 1'b0;
    end else begin
      wake_run_r <= wake_now && !(skip_r && !interrupt_controller_block_irq); // RL23
      wake_skip_r <= wake_now && skip_r && !interrupt_controller_block_irq; // RL24
    end
  end

  // ==========================================================================
  // Outputs
  assign reset_cause_scratch = cause_r;
  assign core_ext_irq_first_n = irq1_r;
  assign core_ext_irq_second_n = irq2_r;
  assign pll_enable = pll_en_r;
  assign pll_stable = pll_stable_r;
  assign core_clk_en = run_r;
  assign core_timers_run = run_r;
  assign core_fetch_en = fetch_r;
  assign mode_state = mode_r;
  assign wake_run_isr = wake_run_r;
  assign wake_skip_isr = wake_skip_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_pfail_first_irq: assert property (!pin_s_r[rpm_pkg::PIN_PFAIL] |=> !core_ext_irq_first_n) // RL1
    else $error("power fail did not raise first irq");
  a_first_over_second: assert property (!core_ext_irq_first_n |-> core_ext_irq_second_n) // RL1
    else $error("second irq active with first");
  a_battery_scope: assert property (!pin_s_r[rpm_pkg::PIN_BAT] |-> !battery_region_rst_n) // RL2
    else $error("battery reset missing");
  a_stby_pll_first: assert property ($rose(stby_done_r) |-> $past(pll_stable_r)) // RL3
    else $error("standby reset done before pll settled");
  a_host_sources: assert property (host_src |-> !host_region_rst_n && !host_soft_rst_n) // RL5
    else $error("host region not reset");
  a_soft_scope: assert property ((superio_soft_reset_write && host_region_rst_n && !host_src)
    ##1 !host_src |-> host_region_rst_n && !host_soft_rst_n) // RL6
    else $error("software reset scope wrong");
  a_wdog_ctrl: assert property (core_wdt_timeout || ext_wdt_timeout
    |-> !ctrl_domain_rst_n ##1 !ctrl_domain_rst_n) // RL8
    else $error("watchdog reset too short");
  a_bad_key: assert property (key_bad |-> !ctrl_domain_rst_n) // RL9
    else $error("bad key did not reset");
  a_cause_core: assert property (core_wdt_timeout && !wdog_ext && !warm_act && stby_done_r
    |=> reset_cause_scratch == rpm_pkg::CAUSE_WDT_CORE) // RL10
    else $error("core watchdog cause lost");
  a_div_default: assert property (!ctrl_domain_rst_n |=> clock_divide_select == rpm_pkg::DIV_BY2) // RL13
    else $error("divider not at default");
  a_idle_fetch: assert property (mode_r == rpm_pkg::MODE_IDLE |-> !core_fetch_en && core_timers_run) // RL16
    else $error("idle gating wrong");
  a_idle_wake: assert property (mode_r == rpm_pkg::MODE_IDLE && core_timer_irq && ctrl_domain_rst_n
    |=> mode_r == rpm_pkg::MODE_NORMAL) // RL17
    else $error("idle did not wake");
  a_low_power_stop: assert property ((mode_r == rpm_pkg::MODE_DOZE || mode_r == rpm_pkg::MODE_SLEEP)
    |-> !core_clk_en && !core_timers_run) // RL18
    else $error("core runs in low power");
  a_doze_holds: assert property (mode_r == rpm_pkg::MODE_DOZE && !interrupt_controller_block_irq && ctrl_domain_rst_n
    |=> mode_r == rpm_pkg::MODE_DOZE) // RL19
    else $error("doze left without irq");
  a_sleep_pll_off: assert property (mode_r == rpm_pkg::MODE_SLEEP |-> !pll_enable) // RL20
    else $error("pll runs in sleep");
  a_relock_wait: assert property (mode_r == rpm_pkg::MODE_RELOCK && !pll_stable_r && ctrl_domain_rst_n
    |=> mode_r == rpm_pkg::MODE_RELOCK) // RL21
    else $error("sleep woke before pll settled");
  a_doze_isr: assert property (mode_r == rpm_pkg::MODE_DOZE && interrupt_controller_block_irq && ctrl_domain_rst_n
    |=> wake_run_isr && !wake_skip_isr) // RL23
    else $error("wake did not run routine");

  c_sleep_wake: cover property (mode_r == rpm_pkg::MODE_RELOCK ##[1:1000] mode_r == rpm_pkg::MODE_NORMAL);
  c_idle_wake: cover property (mode_r == rpm_pkg::MODE_IDLE ##1 mode_r == rpm_pkg::MODE_NORMAL);
  c_skip_isr: cover property (wake_skip_isr);
  c_key_reset: cover property (key_bad ##1 !ctrl_domain_rst_n);

endmodule

/* File: bench/core_firmware_model.sv */
// Purpose: Firmware-side model that raises the core's wake interrupts.
// Assumes: The bench asks for an interrupt by holding a request level.
// Notes: Each request level turns into an interrupt level one clock later.
`timescale 1ns/1ps
module core_firmware_model (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic req_interrupt_controller_block,
  input wire logic req_timer,
  // Interrupt levels toward the design
  output logic interrupt_controller_block_irq,
  output logic core_timer_irq
);
  // Each interrupt level follows its request level on the next rising clock edge, with no reset.
  // Only the channel that is asked for is enabled and raised.
  always @(posedge clk) begin
    interrupt_controller_block_irq <= req_interrupt_controller_block;
    core_timer_irq <= req_timer;
  end
endmodule

/* File: bench/test_reset_and_power_mode_control.sv */
// Purpose: Self-checking bench for the reset and power mode controller.
// Assumes: The PLL settle count is shortened to 8 cycles.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ps
module test_reset_and_power_mode_control;
  logic clk = 0, rst_n = 0, battery_supply = 0, standby_supply = 0, main_supply = 0;
  logic warm_reset_n = 1, host_bus_reset_a_n = 1, host_bus_reset_b_n = 1, host_reset_pin_sel = 0;
  logic host_reset_use = 0, power_fail_n = 1, alt_irq_pin_n = 1, superio_soft_reset_write = 0;
  logic core_wdt_timeout = 0, ext_wdt_timeout = 0, ext_watchdog_key_enable = 0, ext_watchdog_key_write = 0;
  logic [7:0] ext_watchdog_key_data = 8'h00;
  logic clock_divide_write = 0, idle_bit_set = 0, power_down_bit_set = 0, pll_stop_ctrl = 0;
  logic [1:0] clock_divide_data = 2'h0;
  logic skip_isr_on_wake_bit = 0, req_interrupt_controller_block = 0, req_timer = 0, interrupt_controller_block_irq, core_timer_irq;
  logic battery_region_rst_n, host_region_rst_n, host_soft_rst_n, ctrl_domain_rst_n;
  logic core_ext_irq_first_n, core_ext_irq_second_n, pll_enable, pll_stable, ctrl_clk_tick;
  logic core_clk_en, core_fetch_en, core_timers_run, wake_run_isr, wake_skip_isr;
  logic [2:0] reset_cause_scratch, mode_state;
  logic [1:0] clock_divide_select;
  int mismatches = 0, checked = 0, waited;

  always #50 clk = ~clk;

  reset_and_power_mode_control #(.PLL_SETTLE_CYC(8)) i_dut (.clk, .rst_n, .battery_supply, .standby_supply,
    .main_supply, .warm_reset_n, .host_bus_reset_a_n, .host_bus_reset_b_n, .host_reset_pin_sel,
    .host_reset_use, .power_fail_n, .alt_irq_pin_n, .superio_soft_reset_write, .core_wdt_timeout,
    .ext_wdt_timeout, .ext_watchdog_key_enable, .ext_watchdog_key_write, .ext_watchdog_key_data,
    .clock_divide_write, .clock_divide_data, .idle_bit_set, .power_down_bit_set, .pll_stop_ctrl,
    .skip_isr_on_wake_bit, .interrupt_controller_block_irq, .core_timer_irq, .battery_region_rst_n, .host_region_rst_n,
    .host_soft_rst_n, .ctrl_domain_rst_n, .reset_cause_scratch, .core_ext_irq_first_n,
    .core_ext_irq_second_n, .pll_enable, .pll_stable, .ctrl_clk_tick, .clock_divide_select, .core_clk_en,
    .core_fetch_en, .core_timers_run, .mode_state, .wake_run_isr, .wake_skip_isr);
  core_firmware_model i_fw (.clk, .req_interrupt_controller_block, .req_timer, .interrupt_controller_block_irq, .core_timer_irq);

  task complete_run();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task step();
    @(negedge clk);
  endtask

  task chk(input string n, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      mismatches++;
    end
  endtask

  // Waits, bounded, for a mode with the controller domain out of reset.
  task wait_on(input logic [2:0] m);
    waited = 0;
    while (!(mode_state === m && ctrl_domain_rst_n === 1'b1)) begin
      step();
      waited++;
      if (waited > 200) begin
        $display("CHECK FAILED wait expected %0h seen %0h", m, mode_state);
        mismatches++;
        complete_run();
      end
    end
  endtask

  task power_up();
    battery_supply = 1;
    standby_supply = 1;
    main_supply = 1;
    wait_on(3'h1);
    chk("cause", 3'h1, reset_cause_scratch);
    chk("bat_rst", 3'h1, {2'b0, battery_region_rst_n});
    chk("div", 3'h1, {1'b0, clock_divide_select});
    chk("fetch", 3'h1, {2'b0, core_fetch_en});
  endtask

  task reset_pins();
    warm_reset_n = 0;
    repeat (3) step();
    chk("host_rst", 3'h0, {2'b0, host_region_rst_n});
    chk("ctrl_rst", 3'h0, {2'b0, ctrl_domain_rst_n});
    warm_reset_n = 1;
    wait_on(3'h1);
    chk("cause", 3'h2, reset_cause_scratch);
    host_reset_use = 1;
    host_reset_pin_sel = 1;
    host_bus_reset_b_n = 0;
    repeat (4) step();
    chk("host_rst", 3'h0, {2'b0, host_region_rst_n});
    chk("ctrl_rst", 3'h1, {2'b0, ctrl_domain_rst_n});
    chk("irq2", 3'h0, {2'b0, core_ext_irq_second_n});
    host_bus_reset_b_n = 1;
    repeat (6) step();
    chk("host_rst", 3'h1, {2'b0, host_region_rst_n});
    host_reset_pin_sel = 0;
    host_bus_reset_b_n = 0;
    repeat (4) step();
    chk("host_rst", 3'h1, {2'b0, host_region_rst_n});
    host_bus_reset_b_n = 1;
    superio_soft_reset_write = 1;
    step();
    superio_soft_reset_write = 0;
    chk("soft_rst", 3'h0, {2'b0, host_soft_rst_n});
    chk("host_rst", 3'h1, {2'b0, host_region_rst_n});
    repeat (3) step();
    chk("soft_rst", 3'h1, {2'b0, host_soft_rst_n});
  endtask

  task watchdogs();
    ext_watchdog_key_enable = 1;
    for (int k = 0; k < 3; k++) begin
      ext_watchdog_key_write = (k == 0);
      core_wdt_timeout = (k == 1);
      ext_wdt_timeout = (k == 2);
      step();
      {ext_watchdog_key_write, core_wdt_timeout, ext_wdt_timeout} = 3'h0;
      chk("ctrl_rst", 3'h0, {2'b0, ctrl_domain_rst_n});
      chk("cause", (k == 1) ? 3'h4 : 3'h3, reset_cause_scratch);
      wait_on(3'h1);
    end
    ext_watchdog_key_data = rpm_pkg::EXT_WDT_KEY;
    ext_watchdog_key_write = 1;
    step();
    ext_watchdog_key_write = 0;
    chk("ctrl_rst", 3'h1, {2'b0, ctrl_domain_rst_n});
  endtask

  task divider();
    int n;
    n = 0;
    repeat (8) begin
      step();
      n += ctrl_clk_tick;
    end
    chk("ticks_div2", 3'h4, 3'(n));
    clock_divide_write = 1;
    step();
    clock_divide_write = 0;
    step();
    chk("div", 3'h0, {1'b0, clock_divide_select});
    chk("tick", 3'h1, {2'b0, ctrl_clk_tick});
  endtask

  task low_power(input logic stop, input logic [2:0] m);
    pll_stop_ctrl = stop;
    power_down_bit_set = 1;
    step();
    power_down_bit_set = 0;
    chk("mode", m, mode_state);
    chk("pll_en", {2'b0, ~stop}, {2'b0, pll_enable});
    chk("core_clk", 3'h0, {2'b0, core_clk_en});
    chk("timers", 3'h0, {2'b0, core_timers_run});
    req_timer = 1;
    repeat (4) step();
    chk("mode", m, mode_state);
    chk("pll_stable", {2'b0, ~stop}, {2'b0, pll_stable});
    req_timer = 0;
    req_interrupt_controller_block = 1;
    wait_on(3'h1);
    chk("run_isr", 3'h1, {2'b0, wake_run_isr});
    chk("slow_wake", {2'b0, stop}, {2'b0, waited > 8});
    req_interrupt_controller_block = 0;
    step();
  endtask

  task idle();
    skip_isr_on_wake_bit = 1;
    idle_bit_set = 1;
    step();
    idle_bit_set = 0;
    chk("mode", 3'h2, mode_state);
    chk("fetch", 3'h0, {2'b0, core_fetch_en});
    chk("timers", 3'h1, {2'b0, core_timers_run});
    req_timer = 1;
    wait_on(3'h1);
    chk("skip_isr", 3'h1, {2'b0, wake_skip_isr});
    req_timer = 0;
    skip_isr_on_wake_bit = 0;
    step();
  endtask

  task power_fail();
    power_fail_n = 0;
    alt_irq_pin_n = 0;
    repeat (4) step();
    chk("irq1", 3'h0, {2'b0, core_ext_irq_first_n});
    chk("irq2", 3'h1, {2'b0, core_ext_irq_second_n});
    power_fail_n = 1;
    repeat (4) step();
    chk("irq1", 3'h1, {2'b0, core_ext_irq_first_n});
    chk("irq2", 3'h0, {2'b0, core_ext_irq_second_n});
    alt_irq_pin_n = 1;
  endtask

  initial begin
    repeat (3) step();
    rst_n = 1;
    power_up();
    reset_pins();
    watchdogs();
    divider();
    low_power(1'b0, 3'h3);
    low_power(1'b1, 3'h4);
    idle();
    power_fail();
    complete_run();
  end
endmodule
